//--- hw/nfc_pkg.sv
package nfc_pkg;
  // command codes
  localparam logic [7:0] CMD_RESET     = 8'hF0;
  localparam logic [7:0] CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0] CMD_IDENT     = 8'h90;
  localparam logic [7:0] CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0] CMD_BYPASS    = 8'h20;
  localparam logic [7:0] CMD_ERASE     = 8'h80;
  localparam logic [7:0] CMD_CHIP      = 8'h10;
  localparam logic [7:0] CMD_BLOCK     = 8'h30;
  localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0] CMD_RESUME    = 8'h30;
  localparam logic [7:0] CMD_BYP_EXIT  = 8'h00;
  // unlock addresses, word and byte organisation
  localparam logic [11:0] ADR_W_FIRST  = 12'h555;
  localparam logic [11:0] ADR_W_SECOND = 12'h2AA;
  localparam logic [11:0] ADR_B_FIRST  = 12'hAAA;
  localparam logic [11:0] ADR_B_SECOND = 12'h555;
  // bus widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  // bus cycle phase lengths in clock cycles (8 ns clock)
  localparam int CLK_NS        = 8;
  localparam int SETUP_NS      = 20;
  localparam int PULSE_NS      = 40;
  localparam int HOLD_NS       = 20;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // read/reset abort wait
  localparam int ABORT_US      = 10;
  localparam int ABORT_CYC     = ABORT_US * 1000 / CLK_NS;
  // status polling: toggle bit and error bit positions
  localparam int ST_TOGGLE     = 6;
  localparam int ST_ERROR      = 5;
  localparam int CNT_W         = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // host operations requested by user logic
  typedef enum logic [3:0] {
    NFC_OP_READ    = 4'h0,
    NFC_OP_RESET   = 4'h1,
    NFC_OP_IDENT   = 4'h2,
    NFC_OP_PROGRAM = 4'h3,
    NFC_OP_BYP_ON  = 4'h4,
    NFC_OP_BYP_PGM = 4'h5,
    NFC_OP_BYP_OFF = 4'h6,
    NFC_OP_CHIP    = 4'h7,
    NFC_OP_BLOCK   = 4'h8,
    NFC_OP_SUSPEND = 4'h9,
    NFC_OP_RESUME  = 4'hA
  } nfc_op_t;

  typedef struct packed {
    nfc_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nfc_req_t;

  typedef struct packed {
    logic              ok;
    logic              err;
    logic [DATA_W-1:0] data;
  } nfc_rsp_t;

  // one flash bus cycle for the pin driver
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nfc_cyc_t;

  // unlock/command address for a given organisation and step
  function automatic logic [ADDR_W-1:0] nfc_cmd_addr(input logic byteMode,
                                                    input logic second);
    logic [11:0] a;
    a = byteMode ? (second ? ADR_B_SECOND : ADR_B_FIRST)
                 : (second ? ADR_W_SECOND : ADR_W_FIRST);
    return {{(ADDR_W-12){1'b0}}, a};
  endfunction
endpackage

//--- hw/nfc_bus_cycle.sv
`timescale 1ns/1ps
// one asynchronous bus cycle on the flash pins
module nfc_bus_cycle (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      start,
  input  wire nfc_pkg::nfc_cyc_t         cyc,
  output logic                           done,
  output logic [nfc_pkg::DATA_W-1:0]     rdData,
  output logic                           ceN,
  output logic                           weN,
  output logic                           oeN,
  output logic [nfc_pkg::ADDR_W-1:0]     addrOut,
  output logic [nfc_pkg::DATA_W-1:0]     dqOut,
  output logic                           dqOe,
  input  wire logic [nfc_pkg::DATA_W-1:0] dqIn
);
  import nfc_pkg::*;

  typedef enum logic [1:0] {
    BC_IDLE  = 2'b00,
    BC_SETUP = 2'b01,
    BC_PULSE = 2'b11,
    BC_HOLD  = 2'b10
  } nfc_bc_t;

  nfc_bc_t           state_r;   // phase
  logic [7:0]        cnt_r;     // phase timer
  logic              wr_r;      // cycle is a write
  logic [DATA_W-1:0] s1_r;      // read data sync stages
  logic [DATA_W-1:0] s2_r;
  logic [DATA_W-1:0] s3_r;

  // data pins are asynchronous; three stages, use once the two late stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
    end else begin
      s1_r <= dqIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // sequencer: address before strobe falls, data latched on rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= BC_IDLE;
      cnt_r   <= 8'h00;
      wr_r    <= 1'b0;
      ceN     <= 1'b1;
      weN     <= 1'b1;
      oeN     <= 1'b1;
      addrOut <= '0;
      dqOut   <= 16'h0000;
      dqOe    <= 1'b0;
      done    <= 1'b0;
      rdData  <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (state_r)
        BC_IDLE: begin
          if (start) begin
            wr_r    <= cyc.wr;
            addrOut <= cyc.addr;
            dqOut   <= cyc.data;
            dqOe    <= cyc.wr;
            ceN     <= 1'b0;
            cnt_r   <= 8'(SETUP_CYC);
            state_r <= BC_SETUP;
          end
        end
        BC_SETUP: begin
          if (cnt_r <= 8'h01) begin
            // write strobe falls last, so address latched here
            weN     <= !wr_r;
            oeN     <= wr_r;
            // reads need extra cycles for the sync stages
            cnt_r   <= 8'(PULSE_CYC + (wr_r ? 0 : 3));
            state_r <= BC_PULSE;
          end else cnt_r <= cnt_r - 8'h01;
        end
        BC_PULSE: begin
          if (cnt_r <= 8'h01) begin
            // write strobe rises first, data latched here
            weN     <= 1'b1;
            oeN     <= 1'b1;
            // only a value that both late stages agree on counts
            if (!wr_r && s2_r == s3_r) rdData <= s3_r;
            cnt_r   <= 8'(HOLD_CYC);
            state_r <= BC_HOLD;
          end else cnt_r <= cnt_r - 8'h01;
        end
        BC_HOLD: begin
          if (cnt_r <= 8'h01) begin
            ceN     <= 1'b1;
            dqOe    <= 1'b0;
            done    <= 1'b1;
            state_r <= BC_IDLE;
          end else cnt_r <= cnt_r - 8'h01;
        end
        default: state_r <= BC_IDLE;
      endcase
    end
  end
endmodule

//--- hw/nfc_host.sv
`timescale 1ns/1ps
// Function
// - reset is F0 at any address
// - identify takes three writes ending 90
// - program: four writes, A0 third
// - error needs reset to clear status
// - word mode unlock 555/2AA
// - byte mode unlock AAA/555
// - command byte selects the operation
// - erase six writes, 10 or 30
// - bypass program, exit, suspend, resume
module nfc_host (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        byteMode,
  input  wire logic                        reqValid,
  input  wire nfc_pkg::nfc_req_t           req,
  output logic                             reqReady,
  output nfc_pkg::nfc_rsp_t                rsp,
  output logic                             rspValid,
  output logic                             inBypass,
  output logic                             ceN,
  output logic                             weN,
  output logic                             oeN,
  output logic [nfc_pkg::ADDR_W-1:0]       addrOut,
  output logic [nfc_pkg::DATA_W-1:0]       dqOut,
  output logic                             dqOe,
  input  wire logic [nfc_pkg::DATA_W-1:0]  dqIn
);
  import nfc_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_ISSUE = 3'b001,
    H_WAIT  = 3'b011,
    H_POLL  = 3'b010,
    H_POLLW = 3'b110,
    H_ABORT = 3'b111,
    H_DONE  = 3'b101
  } nfc_hs_t;

  nfc_hs_t           state_r;    // main sequence state
  nfc_req_t          req_r;      // latched request
  logic [2:0]        step_r;     // write index in sequence
  logic [2:0]        len_r;      // sequence length
  logic              poll_r;     // operation needs status polling
  logic              bypass_r;   // bypass mode tracking
  logic [DATA_W-1:0] prevSt_r;   // previous status for toggle check
  logic              havePrev_r; // one status read already taken
  logic [CNT_W-1:0]  abortCnt_r; // abort timer
  logic              start_r;    // bus cycle start pulse
  nfc_cyc_t          cyc_r;      // bus cycle being issued
  logic              cycDone;
  logic [DATA_W-1:0] cycData;

  // pins come from the cycle driver flops
  nfc_bus_cycle u_cyc (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (start_r),
    .cyc     (cyc_r),
    .done    (cycDone),
    .rdData  (cycData),
    .ceN     (ceN),
    .weN     (weN),
    .oeN     (oeN),
    .addrOut (addrOut),
    .dqOut   (dqOut),
    .dqOe    (dqOe),
    .dqIn    (dqIn)
  );

  // length of each write sequence
  function automatic logic [2:0] seq_len(input nfc_op_t op);
    unique case (op)
      NFC_OP_READ:    return 3'd1;
      NFC_OP_RESET:   return 3'd1;
      NFC_OP_SUSPEND: return 3'd1;
      NFC_OP_RESUME:  return 3'd1;
      NFC_OP_BYP_PGM: return 3'd2;
      NFC_OP_BYP_OFF: return 3'd2;
      NFC_OP_IDENT:   return 3'd3;
      NFC_OP_BYP_ON:  return 3'd3;
      NFC_OP_PROGRAM: return 3'd4;
      NFC_OP_CHIP:    return 3'd6;
      NFC_OP_BLOCK:   return 3'd6;
      default:        return 3'd1;
    endcase
  endfunction

  // build the bus cycle for write step s of the request
  function automatic nfc_cyc_t seq_cyc(input nfc_req_t r, input logic [2:0] s,
                                       input logic bm);
    nfc_cyc_t c;
    logic [7:0] code;
    c.wr   = 1'b1;
    c.addr = nfc_cmd_addr(bm, 1'b0);
    c.data = 16'h0000;
    code   = 8'h00;
    unique case (r.op)
      NFC_OP_IDENT:   code = CMD_IDENT;
      NFC_OP_PROGRAM: code = CMD_PROGRAM;
      NFC_OP_BYP_ON:  code = CMD_BYPASS;
      default:        code = CMD_ERASE;
    endcase
    if (s == 3'd0 || s == 3'd3) c.data = {8'h00, CMD_UNLOCK1};
    if (s == 3'd1 || s == 3'd4) begin
      c.addr = nfc_cmd_addr(bm, 1'b1);
      c.data = {8'h00, CMD_UNLOCK2};
    end
    if (s == 3'd2) c.data = {8'h00, code};
    // fourth write carries target and value
    if (r.op == NFC_OP_PROGRAM && s == 3'd3) begin
      c.addr = r.addr;
      c.data = r.data;
    end
    if (s == 3'd5) begin
      c.data = {8'h00, (r.op == NFC_OP_CHIP) ? CMD_CHIP : CMD_BLOCK};
      if (r.op == NFC_OP_BLOCK) c.addr = r.addr;
    end
    // single and two write forms
    unique case (r.op)
      NFC_OP_READ: begin
        c.wr   = 1'b0;
        c.addr = r.addr;
      end
      NFC_OP_RESET:   c.data = {8'h00, CMD_RESET};
      NFC_OP_SUSPEND: c.data = {8'h00, CMD_SUSPEND};
      NFC_OP_RESUME:  c.data = {8'h00, CMD_RESUME};
      NFC_OP_BYP_PGM: begin
        c.addr = (s == 3'd0) ? '0 : r.addr;
        c.data = (s == 3'd0) ? {8'h00, CMD_PROGRAM} : r.data;
      end
      NFC_OP_BYP_OFF: begin
        c.addr = '0;
        c.data = {8'h00, (s == 3'd0) ? CMD_IDENT : CMD_BYP_EXIT};
      end
      default: c.wr = 1'b1;
    endcase
    return c;
  endfunction

  // main sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= H_IDLE;
      req_r      <= '0;
      step_r     <= 3'd0;
      len_r      <= 3'd1;
      poll_r     <= 1'b0;
      prevSt_r   <= 16'h0000;
      havePrev_r <= 1'b0;
      abortCnt_r <= CNT_RST;
      reqReady   <= 1'b1;
      start_r    <= 1'b0;
      cyc_r      <= '0;
      rsp        <= '0;
      rspValid   <= 1'b0;
    end else begin
      start_r  <= 1'b0;
      rspValid <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          // one request at a time, accepted only here
          // ready returns a cycle after the answer pulse, so a request
          // still held through that pulse is not taken a second time
          reqReady <= !(reqValid && reqReady);
          if (reqValid && reqReady) begin
            req_r   <= req;
            step_r  <= 3'd0;
            len_r   <= seq_len(req.op);
            poll_r  <= req.op == NFC_OP_PROGRAM ||
                       req.op == NFC_OP_BYP_PGM ||
                       req.op == NFC_OP_CHIP ||
                       req.op == NFC_OP_BLOCK ||
                       req.op == NFC_OP_RESUME;
            state_r <= H_ISSUE;
          end
        end
        H_ISSUE: begin
          // each write is a full strobe cycle
          cyc_r   <= seq_cyc(req_r, step_r, byteMode);
          start_r <= 1'b1;
          state_r <= H_WAIT;
        end
        H_WAIT: begin
          if (cycDone) begin
            if (step_r + 3'd1 < len_r) begin
              step_r  <= step_r + 3'd1;
              state_r <= H_ISSUE;
            end else if (poll_r) begin
              havePrev_r <= 1'b0;
              cyc_r      <= '{wr: 1'b0, addr: req_r.addr, data: 16'h0000};
              start_r    <= 1'b1;
              state_r    <= H_POLLW;
            end else if (req_r.op == NFC_OP_RESET) begin
              // allow abort time before any read
              abortCnt_r <= CNT_W'(ABORT_CYC);
              state_r    <= H_ABORT;
            end else begin
              rsp     <= '{ok: 1'b1, err: 1'b0, data: cycData};
              state_r <= H_DONE;
            end
          end
        end
        H_POLLW: begin
          if (cycDone) begin
            prevSt_r   <= cycData;
            havePrev_r <= 1'b1;
            // toggle stops once the controller is idle
            if (havePrev_r && cycData[ST_TOGGLE] == prevSt_r[ST_TOGGLE]) begin
              // protected target never toggles: ends here quietly
              rsp     <= '{ok: 1'b1, err: 1'b0, data: cycData};
              state_r <= H_DONE;
            end else if (havePrev_r && prevSt_r[ST_ERROR]) begin
              // error: flash keeps status until reset
              rsp     <= '{ok: 1'b0, err: 1'b1, data: cycData};
              state_r <= H_DONE;
            end else state_r <= H_POLL;
          end
        end
        H_POLL: begin
          start_r <= 1'b1;
          state_r <= H_POLLW;
        end
        H_ABORT: begin
          if (abortCnt_r == CNT_RST) begin
            rsp     <= '{ok: 1'b1, err: 1'b0, data: 16'h0000};
            state_r <= H_DONE;
          end else abortCnt_r <= abortCnt_r - 16'h0001;
        end
        H_DONE: begin
          rspValid <= 1'b1;
          state_r  <= H_IDLE;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // track bypass mode for the user
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bypass_r <= 1'b0;
    else if (state_r == H_DONE && req_r.op == NFC_OP_BYP_ON) bypass_r <= 1'b1;
    else if (state_r == H_DONE && req_r.op == NFC_OP_BYP_OFF)
      bypass_r <= 1'b0;
  end
  assign inBypass = bypass_r;
endmodule

//--- test/nfc_host_asserts.sv
`timescale 1ns/1ps
module nfc_host_asserts (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       reqValid,
  input wire logic                       reqReady,
  input wire logic                       rspValid,
  input wire logic                       ceN,
  input wire logic                       weN,
  input wire logic                       oeN,
  input wire logic [nfc_pkg::ADDR_W-1:0] addrOut,
  input wire logic [nfc_pkg::DATA_W-1:0] dqOut,
  input wire logic                       dqOe
);
  import nfc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_WE_FRAMED: assert property (!weN |-> !ceN && oeN && dqOe)
    else $error("write strobe outside a driven cycle");
  AST_READ_FREE: assert property (!oeN |-> !dqOe && weN)
    else $error("host drives data during a read");
  AST_SETUP: assert property ($fell(ceN) && dqOe |-> weN[*3] ##1 !weN)
    else $error("write setup not three cycles");
  AST_PULSE: assert property ($fell(weN) |-> !weN[*5] ##1 weN)
    else $error("write pulse not five cycles");
  AST_HOLD: assert property ($rose(weN) |-> (!ceN && dqOe)[*3] ##1 ceN)
    else $error("write hold not three cycles");
  AST_STABLE: assert property (!weN ##1 !weN |-> $stable({addrOut, dqOut}))
    else $error("address or data moved under the strobe");
  AST_RSP_PULSE: assert property (rspValid |=> !rspValid)
    else $error("answer longer than one cycle");
  AST_RSP_IDLE: assert property (rspValid |-> ceN && weN && oeN)
    else $error("answer given while the bus is busy");
  AST_RSP_CAUSE: assert property (rspValid |-> $past(reqValid))
    else $error("answer without a request");
  AST_TAKE_ONCE: assert property (reqValid && reqReady |=> !reqReady)
    else $error("ready still high after a request was taken");
  AST_RSP_BUSY: assert property (rspValid |-> !reqReady)
    else $error("ready high together with the answer pulse");
endmodule
bind nfc_host nfc_host_asserts i_nfc_host_asserts (.clk(clk), .rst_n(rst_n),
  .reqValid(reqValid), .reqReady(reqReady), .rspValid(rspValid),
  .ceN(ceN), .weN(weN),
  .oeN(oeN), .addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe));

//--- test/nfc_flash_model.sv
`timescale 1ns/1ps
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter logic [15:0] MAKER    = 16'h0A5A, // arbitrary value
  parameter logic [15:0] DEVICE   = 16'h0B6B, // arbitrary value
  parameter logic [5:0]  PROT_BLK = 6'h05     // the protected block
)(
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] wrData,
  output      logic [15:0] rdData,
  input  wire logic        byteMode,
  input  wire logic        errInject,
  input  wire logic [3:0]  busyLen
);
  logic [15:0] mem [logic [17:0]]; // unwritten reads as erased
  logic [17:0] la, pa;
  logic [15:0] rdVal = 16'h0000, pd;
  logic        idMode = 1'b0, byp = 1'b0, busy = 1'b0, tog = 1'b0;
  logic [5:0]  eb;
  int          step = 0, cnt = 0, kind = 0;
  // released bus shows the inverse, never a held value
  assign rdData = (!ceN && !oeN) ? rdVal : ~rdVal;
  task automatic start(input int k);
    busy = 1'b1;
    cnt = busyLen;
    kind = k;
  endtask
  // protected target dropped, else controller starts
  task automatic pgm(input logic [17:0] a, input logic [15:0] v);
    if (a[17:12] != PROT_BLK) begin
      pa = a;
      pd = v;
      start(0);
    end
  endtask
  // program only clears bits, erase sets them
  task automatic complete();
    busy = 1'b0;
    if (kind == 0) mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hFFFF) & pd;
    else foreach (mem[k]) if (kind == 1 || k[17:12] == eb) mem[k] = '1;
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic u1, u2;
    u1 = byteMode ? a[11:0] == 12'hAAA : a[10:0] == 11'h555;
    u2 = byteMode ? a[11:0] == 12'h555 : a[10:0] == 11'h2AA;
    // busy ignores all but reset of an error
    if (busy) busy = !(errInject && d == CMD_RESET);
    // bypass takes only its program and exit
    else if (byp) begin
      if (step == 10) pgm(a, wrData);
      if (step == 11) byp = d != CMD_BYP_EXIT;
      step = step > 9 ? 0 : d == CMD_PROGRAM ? 10 : d == CMD_IDENT ? 11 : 0;
    end else if (d == CMD_RESET) begin
      step = 0;
      idMode = 1'b0;
    // any break falls back to read
    end else case (step)
      0: step = (d == CMD_UNLOCK1 && u1) ? 1 : 0;
      1: step = (d == CMD_UNLOCK2 && u2) ? 2 : 0;
      2: begin
        idMode = u1 && d == CMD_IDENT;
        byp = u1 && d == CMD_BYPASS;
        step = !u1 ? 0 : d == CMD_PROGRAM ? 3 : d == CMD_ERASE ? 4 : 0;
      end
      3: begin
        pgm(a, wrData);
        step = 0;
      end
      4: step = (d == CMD_UNLOCK1 && u1) ? 5 : 0;
      5: step = (d == CMD_UNLOCK2 && u2) ? 6 : 0;
      default: begin
        eb = a[17:12];
        if (d == CMD_CHIP && u1) start(1);
        if (d == CMD_BLOCK) start(2);
        step = 0;
      end
    endcase
  endtask
  // address on the later fall, data on the first rise
  always @(negedge ceN or negedge weN) la = addr;
  always @(posedge weN) if (!ceN) wr(la, wrData[7:0]);
  always @(negedge oeN) begin
    if (busy) begin
      tog = ~tog;
      rdVal = {9'h000, tog, errInject, 5'h00};
      if (!errInject && cnt == 0) complete();
      else if (!errInject) cnt--;
    // signature and protection by the two low bits
    end else if (idMode) case (addr[1:0])
      2'b00: rdVal = MAKER;
      2'b01: rdVal = DEVICE;
      2'b10: rdVal = {15'h0000, addr[17:12] == PROT_BLK};
      default: rdVal = 16'h0000;
    endcase
    else rdVal = mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import nfc_pkg::*;
  localparam logic [15:0] MAKER  = 16'h0A5A; // arbitrary value
  localparam logic [15:0] DEVICE = 16'h0B6B; // arbitrary value
  localparam logic [5:0]  PROT   = 6'h05;
  logic              clk, rst_n, byteMode, reqValid, rspValid, inBypass;
  logic              ceN, weN, oeN, dqOe, errInject;
  logic [3:0]        busyLen;
  nfc_req_t          req;
  nfc_rsp_t          rsp, got;
  logic [ADDR_W-1:0] addrOut, a;
  logic [DATA_W-1:0] dqOut, dqIn, d;
  logic [15:0]       expMem [logic [17:0]];
  int                n_mismatch = 0, samples_checked = 0, cycles = 0;
  nfc_host i_nfc_host (.clk(clk), .rst_n(rst_n), .byteMode(byteMode),
    .reqValid(reqValid), .req(req), .reqReady(), .rsp(rsp),
    .rspValid(rspValid), .inBypass(inBypass), .ceN(ceN), .weN(weN),
    .oeN(oeN), .addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
  nfc_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE), .PROT_BLK(PROT))
    i_nfc_flash_model (.ceN(ceN), .weN(weN), .oeN(oeN), .addr(addrOut),
    .wrData(dqOut), .rdData(dqIn), .byteMode(byteMode),
    .errInject(errInject), .busyLen(busyLen));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard, several times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] expRd(input logic [17:0] x);
    return expMem.exists(x) ? expMem[x] : 16'hFFFF;
  endfunction
  // hold the request until the answer pulse, bounded wait
  task automatic doOp(input nfc_op_t o, input logic [17:0] x,
                      input logic [15:0] v);
    int n;
    n = 0;
    reqValid <= 1'b1;
    req <= '{o, x, v};
    do begin
      @(posedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < 4000);
    reqValid <= 1'b0;
    got = rsp;
    if (n == 4000) n_mismatch++;
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [17:0] x, input logic [15:0] e);
    doOp(NFC_OP_READ, x, 16'h0000);
    chk(got.data, e); // read data against the expected value e
  endtask
  initial begin
    rst_n = 1'b0;
    byteMode = 1'b0;
    reqValid = 1'b0;
    req = '0;
    errInject = 1'b0;
    busyLen = 4'h0;
    void'($urandom(32'h5053));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // signature and protection in both organisations
    for (int m = 0; m < 2; m++) begin
      byteMode <= m[0];
      a = 18'($urandom);
      doOp(NFC_OP_IDENT, a, 16'h0000);
      rdChk({a[17:2], 2'b00}, MAKER);
      rdChk({a[17:2], 2'b01}, DEVICE);
      rdChk({PROT, a[11:2], 2'b10}, 16'h0001);
      rdChk({6'h02, a[11:2], 2'b10}, 16'h0000);
      doOp(NFC_OP_RESET, a, 16'h0000);
      rdChk({a[17:2], 2'b01}, 16'hFFFF);
    end
    // repeated targets must only lose bits
    for (int i = 0; i < 12; i++) begin
      a = {6'h02, 10'h000, 2'($urandom)};
      d = 16'($urandom);
      byteMode <= 1'($urandom);
      busyLen <= 4'($urandom);
      doOp(NFC_OP_PROGRAM, a, d);
      chk(got.err, 1'b0);
      expMem[a] = expRd(a) & d;
      rdChk(a, expRd(a));
    end
    a = {PROT, 12'h010};
    doOp(NFC_OP_PROGRAM, a, 16'h0000);
    chk(got.err, 1'b0);
    rdChk(a, 16'hFFFF);
    // failing program keeps status until reset
    errInject <= 1'b1;
    a = {6'h03, 12'h020};
    doOp(NFC_OP_PROGRAM, a, 16'h1234);
    chk(got.err, 1'b1);
    doOp(NFC_OP_READ, a, 16'h0000);
    chk(got.data[ST_ERROR], 1'b1);
    doOp(NFC_OP_RESET, a, 16'h0000);
    errInject <= 1'b0;
    rdChk(a, 16'hFFFF);
    doOp(NFC_OP_BYP_ON, a, 16'h0000);
    chk(inBypass, 1'b1);
    a = {6'h04, 12'($urandom)};
    d = 16'($urandom);
    doOp(NFC_OP_BYP_PGM, a, d);
    expMem[a] = expRd(a) & d;
    rdChk(a, expRd(a));
    doOp(NFC_OP_BYP_OFF, a, 16'h0000);
    chk(inBypass, 1'b0);
    doOp(NFC_OP_BLOCK, {6'h02, 12'h000}, 16'h0000);
    foreach (expMem[k])
      if (k[17:12] == 6'h02) expMem[k] = 16'hFFFF;
    rdChk({6'h02, 12'h001}, 16'hFFFF);
    rdChk(a, expRd(a));
    doOp(NFC_OP_SUSPEND, a, 16'h0000);
    chk(got.ok, 1'b1);
    doOp(NFC_OP_RESUME, a, 16'h0000);
    chk(got.ok, 1'b1);
    doOp(NFC_OP_CHIP, a, 16'h0000);
    rdChk(a, 16'hFFFF);
    end_of_test();
  end
endmodule
